/* File: src/board_error_consts.vh */
`ifndef BOARD_ERROR_CONSTS_VH
`define BOARD_ERROR_CONSTS_VH
// =====================================================
// clock and watchdog timing
`define CLK_PERIOD_NS 10
`define WDOG_MIN_US 4
`define WDOG_MAX_US 512
`define WDOG_STEP_CYCLES ((`WDOG_MIN_US * 1000) / `CLK_PERIOD_NS)
`define WDOG_SEL_W 8
`define WDOG_SEL_MAX 8'h80
// =====================================================
// exception vector numbers
`define VEC_BUS_ERROR 8'h02
`define VEC_ILLEGAL 8'h04
`define VEC_LINE_1010 8'h0a
`define VEC_LINE_1111 8'h0b
`define VEC_FP_FIRST 8'h30
`define VEC_FP_LAST 8'h36
`define FP_CODE_MAX 3'h6
`define VEC_AUTO_L7 8'h1f
`define VEC_AUTO_L7_OFFSET 12'h07c
`define PARITY_IRQ_LEVEL 3'h7
`define REMOTE_HALT_BIT 6
`endif

/* File: src/board_error_status_logic.v */
`timescale 1ns/1ns
`include "board_error_consts.vh"
module board_error_status_logic #(
   parameter WDOG_SEL_W = `WDOG_SEL_W,
   parameter WDOG_STEP = `WDOG_STEP_CYCLES
) (
   input wire i_clk,
   input wire i_srst,
   input wire i_double_fault,
   input wire i_odd_stack,
   input wire i_sys_reset_line,
   input wire i_remote_halt_line,
   input wire i_reset_switch,
   input wire i_remote_halt_control_reg_bit6,
   input wire i_vme_owner,
   input wire i_exp_bus_owner,
   input wire i_plugover_owner,
   input wire i_sysfail_drive,
   input wire i_cache_enable,
   input wire i_cache_inhibit_out,
   input wire i_access_rom,
   input wire i_access_dram,
   input wire i_access_vme_std_ext,
   input wire i_wdog_enable,
   input wire [WDOG_SEL_W-1:0] i_wdog_sel,
   input wire i_cycle_start,
   input wire i_cycle_from_bus,
   input wire i_cycle_ack,
   input wire i_access_float_coprocessor,
   input wire i_float_coprocessor_present,
   input wire i_ram_read_valid,
   input wire [31:0] i_ram_data,
   input wire [3:0] i_ram_parity,
   input wire [3:0] i_ram_byte_en,
   input wire i_irq_ack,
   input wire i_illegal_instr,
   input wire [1:0] i_illegal_class,
   input wire i_fp_error,
   input wire [2:0] i_fp_error_code,
   output reg o_halt_indicator,
   output reg o_alternate_master_indicator,
   output reg o_system_fail_indicator,
   output reg o_cache_disable_n,
   output reg o_cacheable,
   output reg o_bus_error_termination,
   output reg o_wdog_timeout,
   output reg o_cycle_end,
   output reg [2:0] o_irq_level,
   output reg o_irq_autovector,
   output reg o_exception,
   output reg [7:0] o_exception_vector,
   output reg o_processor_halted
);

   // =====================================================
   // helpers
   // lanes that were not read carry no valid parity and are skipped
   function parity_bad;
      input [31:0] data;
      input [3:0] par;
      input [3:0] be;
      integer k;
      begin
         parity_bad = 1'b0;
         for (k = 0; k < 4; k = k + 1) begin
            if (be[k] && ((^data[k*8 +: 8]) != par[k])) begin
               parity_bad = 1'b1;
            end
         end
      end
   endfunction

   // a zero select would give a zero limit whose compare value wraps so no timeout comes, so it reads as the shortest period
   function [WDOG_SEL_W-1:0] clamp_sel;
      input [WDOG_SEL_W-1:0] sel;
      reg [WDOG_SEL_W-1:0] top;
      begin
         top = `WDOG_SEL_MAX;
         if (sel == {WDOG_SEL_W{1'b0}}) begin
            clamp_sel = {{(WDOG_SEL_W-1){1'b0}}, 1'b1};
         end else if (sel > top) begin
            clamp_sel = top;
         end else begin
            clamp_sel = sel;
         end
      end
   endfunction

   // codes past the last vector fold onto it rather than reach reserved numbers
   function [7:0] fp_vector;
      input [2:0] code;
      begin
         if (code > `FP_CODE_MAX) begin
            fp_vector = `VEC_FP_LAST;
         end else begin
            fp_vector = `VEC_FP_FIRST + {5'h00, code};
         end
      end
   endfunction

   // =====================================================
   // input synchronisers for off-domain pins
   // backplane and front-panel levels are not on this clock
   reg [1:0] sync_reset_switch;
   reg [1:0] sync_sys_reset;
   reg [1:0] sync_remote_halt;
   reg [1:0] sync_remote_bit6;
   reg [1:0] sync_sysfail;
   always @(posedge i_clk) begin
      if (i_srst) begin
         sync_reset_switch <= 2'h0;
         sync_sys_reset <= 2'h0;
         sync_remote_halt <= 2'h0;
         sync_remote_bit6 <= 2'h0;
         sync_sysfail <= 2'h0;
      end else begin
         sync_reset_switch <= {sync_reset_switch[0], i_reset_switch};
         sync_sys_reset <= {sync_sys_reset[0], i_sys_reset_line};
         sync_remote_halt <= {sync_remote_halt[0], i_remote_halt_line};
         sync_remote_bit6 <= {sync_remote_bit6[0], i_remote_halt_control_reg_bit6};
         sync_sysfail <= {sync_sysfail[0], i_sysfail_drive};
      end
   end
   wire reset_switch_s = sync_reset_switch[1];
   wire sys_reset_s = sync_sys_reset[1];
   wire remote_halt_s = sync_remote_halt[1];
   wire remote_bit6_s = sync_remote_bit6[1];
   wire sysfail_s = sync_sysfail[1];

   // =====================================================
   // halt latch
   reg halted;
   // the remote bit is a level: while it stays set no new halt can stick
   wire hw_release = reset_switch_s | sys_reset_s | remote_bit6_s;
   wire halt_shown = halted | sys_reset_s | remote_halt_s;
   // release beats a fault in the same cycle, the reset also ends the fault
   always @(posedge i_clk) begin
      if (i_srst) begin
         halted <= 1'b0;
      end else if (hw_release) begin
         halted <= 1'b0;
      end else if (i_double_fault || i_odd_stack) begin
         halted <= 1'b1;
      end
   end

   // =====================================================
   // watchdog: limit = sel * 4us, sel 1..128 covers 4..512us
   reg [31:0] wdog_count;
   reg wdog_active;
   reg wdog_from_bus;
   reg fp_absent_cycle;
   wire [WDOG_SEL_W-1:0] sel_clamped = clamp_sel(i_wdog_sel);
   // programmable limit
   // a 32-bit count leaves room for a slower clock or a longer step
   wire [31:0] wdog_limit = sel_clamped * WDOG_STEP;
   // the hit is taken one count early so that the registered pulse lands on the limit
   wire wdog_at_limit = (wdog_count >= wdog_limit - 32'h1);
   wire wdog_hit = wdog_active && i_wdog_enable && !i_cycle_ack && wdog_at_limit;
   // a new start restarts the count and gives up the access before it
   always @(posedge i_clk) begin
      if (i_srst) begin
         wdog_count <= 32'h0;
         wdog_active <= 1'b0;
         wdog_from_bus <= 1'b0;
         fp_absent_cycle <= 1'b0;
      end else if (i_cycle_start) begin
         wdog_count <= 32'h0;
         wdog_active <= 1'b1;
         wdog_from_bus <= i_cycle_from_bus;
         fp_absent_cycle <= i_access_float_coprocessor & ~i_float_coprocessor_present;
      end else if (i_cycle_ack || wdog_hit || !i_wdog_enable) begin
         wdog_count <= 32'h0;
         wdog_active <= 1'b0;
      end else if (wdog_active) begin
         wdog_count <= wdog_count + 32'h1;
      end
   end

   // =====================================================
   // parity interrupt, held until acknowledged
   reg parity_pending;
   wire parity_event = i_ram_read_valid && parity_bad(i_ram_data, i_ram_parity, i_ram_byte_en);
   always @(posedge i_clk) begin
      if (i_srst) begin
         parity_pending <= 1'b0;
      // set wins over acknowledge
      // an error on the acknowledge cycle must not be lost
      end else if (parity_event) begin
         parity_pending <= 1'b1;
      end else if (i_irq_ack) begin
         parity_pending <= 1'b0;
      end
   end

   // =====================================================
   // cacheability of the current access
   // on-card memory
   wire local_cacheable = i_access_rom | i_access_dram;
   wire bus_cacheable = i_access_vme_std_ext & ~i_cache_inhibit_out;

   // =====================================================
   // ownership and interrupt level
   // any foreign master
   wire foreign_owner = i_vme_owner | i_exp_bus_owner | i_plugover_owner;
   wire [2:0] irq_level_now = parity_pending ? `PARITY_IRQ_LEVEL : 3'h0;

   // =====================================================
   // exception choice, watchdog first since it ends a cycle already under way
   reg next_exception;
   reg [7:0] next_exception_vector;
   always @* begin
      next_exception = 1'b0;
      // the vector holds between exceptions so it can be read late
      next_exception_vector = o_exception_vector;
      if (wdog_hit && fp_absent_cycle && !wdog_from_bus) begin
         next_exception = 1'b1;
         next_exception_vector = `VEC_LINE_1111;
      end else if (wdog_hit && !wdog_from_bus) begin
         next_exception = 1'b1;
         next_exception_vector = `VEC_BUS_ERROR;
      end else if (i_illegal_instr) begin
         next_exception = 1'b1;
         case (i_illegal_class)
            2'h1: next_exception_vector = `VEC_LINE_1010;
            2'h2: next_exception_vector = `VEC_LINE_1111;
            default: next_exception_vector = `VEC_ILLEGAL;
         endcase
      end else if (i_fp_error) begin
         next_exception = 1'b1;
         next_exception_vector = fp_vector(i_fp_error_code);
      end
   end

   // =====================================================
   // registered outputs
   always @(posedge i_clk) begin
      if (i_srst) begin
         o_halt_indicator <= 1'b1;
         o_alternate_master_indicator <= 1'b0;
         o_system_fail_indicator <= 1'b0;
         o_cache_disable_n <= 1'b1;
         o_cacheable <= 1'b0;
         o_bus_error_termination <= 1'b0;
         o_wdog_timeout <= 1'b0;
         o_cycle_end <= 1'b0;
         o_irq_level <= 3'h0;
         o_irq_autovector <= 1'b0;
         o_exception <= 1'b0;
         o_exception_vector <= 8'h00;
         o_processor_halted <= 1'b0;
      end else begin
         o_halt_indicator <= halt_shown;
         o_processor_halted <= halted;
         o_alternate_master_indicator <= foreign_owner;
         o_system_fail_indicator <= sysfail_s;
         o_cache_disable_n <= 1'b1;
         o_cacheable <= i_cache_enable & (local_cacheable | bus_cacheable);
         o_wdog_timeout <= wdog_hit;
         // bus error only for processor cycles
         o_bus_error_termination <= wdog_hit & ~wdog_from_bus;
         o_cycle_end <= wdog_hit;
         o_irq_level <= irq_level_now;
         o_irq_autovector <= parity_pending;
         o_exception <= next_exception;
         o_exception_vector <= next_exception_vector;
      end
   end

endmodule // board_error_status_logic

/* File: verif/board_error_checker.sv */
`timescale 1ns/1ns
module board_error_checker (
   input logic i_clk, i_srst, i_double_fault, i_vme_owner, i_exp_bus_owner, i_plugover_owner, i_sysfail_drive,
   input logic i_cache_enable, i_access_rom, i_access_dram, i_wdog_enable, i_fp_error, i_cycle_from_bus,
   input logic [2:0] i_fp_error_code, o_irq_level,
   input logic o_halt_indicator, o_alternate_master_indicator, o_system_fail_indicator, o_cache_disable_n,
   input logic o_cacheable, o_bus_error_termination, o_wdog_timeout, o_cycle_end, o_irq_autovector,
   input logic [7:0] o_exception_vector
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);
   // =====================================
   // properties
   // the latch sets on the fault edge and the light follows one edge later
   property p_halt; i_double_fault |-> ##2 o_halt_indicator; endproperty
   property p_owner; (i_vme_owner | i_exp_bus_owner | i_plugover_owner) |=> o_alternate_master_indicator; endproperty
   // sysfail pin passes a two-flop synchroniser first
   property p_sysf; i_sysfail_drive [*4] |-> o_system_fail_indicator; endproperty
   property p_cdis; o_cache_disable_n; endproperty
   property p_cache; i_cache_enable && (i_access_rom || i_access_dram) |=> o_cacheable; endproperty
   property p_bus_err; o_bus_error_termination |-> o_wdog_timeout && o_cycle_end; endproperty
   property p_bus; o_wdog_timeout && i_cycle_from_bus |-> !o_bus_error_termination; endproperty
   property p_dis; !i_wdog_enable [*3] |-> !o_wdog_timeout; endproperty
   property p_pulse; o_wdog_timeout |=> !o_wdog_timeout; endproperty
   property p_irq; o_irq_autovector |-> o_irq_level == 3'h7; endproperty
   property p_fp; i_fp_error |=>
      o_exception_vector == (($past(i_fp_error_code) > 3'h6) ? 8'h36 : 8'h30 + $past(i_fp_error_code)); endproperty
   // =====================================
   // assertions
   a_halt: assert property (p_halt) else $error("halt not shown");
   a_owner: assert property (p_owner) else $error("owner not shown");
   a_sysf: assert property (p_sysf) else $error("sysfail not shown");
   a_cdis: assert property (p_cdis) else $error("cache disabled");
   a_cache: assert property (p_cache) else $error("not cacheable");
   a_bus_err: assert property (p_bus_err) else $error("stray bus error");
   a_bus: assert property (p_bus) else $error("bus error on bus access");
   a_dis: assert property (p_dis) else $error("timeout while disabled");
   a_pulse: assert property (p_pulse) else $error("timeout too long");
   a_irq: assert property (p_irq) else $error("irq level wrong");
   a_fp: assert property (p_fp) else $error("fp vector wrong");
   c_bus_err: cover property (o_bus_error_termination);
   c_irq: cover property (o_irq_autovector);
   c_halt: cover property (o_halt_indicator ##1 !o_halt_indicator);
endmodule // board_error_checker
bind board_error_status_logic board_error_checker u_board_error_checker (.*);

/* File: verif/cpu_core_model.sv */
`timescale 1ns/1ns
module cpu_core_model (
   input wire logic i_clk,
   input wire logic i_go, i_from_bus, i_fpu_absent,
   input wire logic [7:0] i_ack_delay,
   output logic o_cycle_start, o_cycle_from_bus, o_cycle_ack, o_access_float_coprocessor, o_float_coprocessor_present
);
   logic [7:0] cnt;
   initial begin
      {o_cycle_start, o_cycle_from_bus, o_cycle_ack, o_access_float_coprocessor, o_float_coprocessor_present} = 5'h01;
      cnt = 8'h00;
   end
   // a zero delay never acknowledges, which is what lets the watchdog expire
   always @(posedge i_clk) begin
      o_cycle_start <= i_go;
      o_cycle_ack <= (cnt == 8'h01);
      if (i_go) begin
         cnt <= i_ack_delay;
         o_cycle_from_bus <= i_from_bus;
         o_access_float_coprocessor <= i_fpu_absent;
         o_float_coprocessor_present <= !i_fpu_absent;
      end else if (cnt != 8'h00) begin
         cnt <= cnt - 8'h01;
      end
   end
endmodule // cpu_core_model

/* File: verif/test_board_error_status_logic.sv */
`timescale 1ns/1ns
module test_board_error_status_logic;
   logic i_clk = 0, srst = 1, df = 0, srl = 0, rsw = 0, rb6 = 0, vo = 0, eo = 0, po = 0, sf = 0, ce = 0, ci = 0;
   logic ar = 0, ad = 0, av = 0, we = 0, go = 0, fb = 0, fa = 0, rv = 0, ia = 0, ii = 0, fe = 0, os = 0, rh = 0;
   logic [7:0] sel = 0, dly = 0;
   logic [31:0] rd = 0;
   logic [3:0] rp = 0, be = 0;
   logic [1:0] ic = 0;
   logic [2:0] fc = 0;
   logic [5:0] tc [5] = '{6'b101001, 6'b100101, 6'b001000, 6'b100011, 6'b110010};
   wire cs, cfb, ack, afc, fcp, hi, ami, sfi, cdn, cac, bet, wt, cen, ivo, ex, ph;
   wire [2:0] il;
   wire [7:0] ev;
   int n_fail = 0, n_tests = 0, k;
   always #5 i_clk = ~i_clk;
   cpu_core_model u_cpu_core_model (.i_clk(i_clk), .i_go(go), .i_from_bus(fb), .i_fpu_absent(fa), .i_ack_delay(dly),
      .o_cycle_start(cs), .o_cycle_from_bus(cfb), .o_cycle_ack(ack), .o_access_float_coprocessor(afc),
      .o_float_coprocessor_present(fcp));
   board_error_status_logic #(.WDOG_STEP(4)) u_board_error_status_logic (.i_clk(i_clk), .i_srst(srst),
      .i_double_fault(df), .i_odd_stack(os), .i_sys_reset_line(srl), .i_remote_halt_line(rh),
      .i_reset_switch(rsw), .i_remote_halt_control_reg_bit6(rb6), .i_vme_owner(vo), .i_exp_bus_owner(eo),
      .i_plugover_owner(po), .i_sysfail_drive(sf), .i_cache_enable(ce), .i_cache_inhibit_out(ci), .i_access_rom(ar),
      .i_access_dram(ad), .i_access_vme_std_ext(av), .i_wdog_enable(we), .i_wdog_sel(sel), .i_cycle_start(cs),
      .i_cycle_from_bus(cfb), .i_cycle_ack(ack), .i_access_float_coprocessor(afc), .i_float_coprocessor_present(fcp),
      .i_ram_read_valid(rv), .i_ram_data(rd), .i_ram_parity(rp), .i_ram_byte_en(be), .i_irq_ack(ia),
      .i_illegal_instr(ii), .i_illegal_class(ic), .i_fp_error(fe), .i_fp_error_code(fc), .o_halt_indicator(hi),
      .o_alternate_master_indicator(ami), .o_system_fail_indicator(sfi), .o_cache_disable_n(cdn), .o_cacheable(cac),
      .o_bus_error_termination(bet), .o_wdog_timeout(wt), .o_cycle_end(cen), .o_irq_level(il),
      .o_irq_autovector(ivo), .o_exception(ex), .o_exception_vector(ev), .o_processor_halted(ph));
   task cyc(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   task chk(input logic [31:0] got, exp, input string m);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task conclude;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task t_status;
      df = 1; cyc(1); df = 0; cyc(2);
      chk({hi, ph}, 2'b11, "halt");
      rsw = 1; cyc(5); rsw = 0; cyc(5);
      chk({hi, ph}, 2'b00, "switch release");
      os = 1; cyc(1); os = 0; cyc(2);
      chk({hi, ph}, 2'b11, "odd stack");
      df = 1; cyc(1); df = 0; rb6 = 1; cyc(5); rb6 = 0; cyc(5);
      chk({hi, ph}, 2'b00, "remote release");
      srl = 1; cyc(5);
      chk(hi, 1, "reset line");
      srl = 0; rh = 1; cyc(5);
      chk({hi, ph}, 2'b10, "mailbox halt");
      rh = 0; cyc(5);
      chk(hi, 0, "mailbox halt off");
      for (k = 0; k < 3; k++) begin
         {vo, eo, po} = 3'h1 << k; cyc(2);
         chk(ami, 1, "owner");
      end
      {vo, eo, po} = 0; sf = 1; cyc(5);
      chk({ami, sfi}, 2'b01, "sysfail on");
      sf = 0; cyc(5);
      chk(sfi, 0, "sysfail off");
      $display("status test done");
   endtask
   task t_cache;
      for (k = 0; k < 5; k++) begin
         {ce, ci, ar, ad, av} = tc[k][5:1]; cyc(2);
         chk({cdn, cac}, {1'b1, tc[k][0]}, "cacheable");
      end
      $display("cache test done");
   endtask
   // lim is the expected count of cycles to the timeout, 0 where none may come
   task wd(input logic [7:0] s, input logic bus, absent, input logic [7:0] d, input int lim);
      sel = s; fb = bus; fa = absent; dly = d; go = 1; cyc(1); go = 0;
      k = 0;
      while (wt !== 1'b1 && k < 600) begin
         cyc(1);
         k++;
      end
      chk(k, lim ? lim + 1 : 600, "timeout time");
      if (lim != 0 && k == 600) conclude;
      if (lim != 0) begin
         chk({bet, cen, ex}, {!bus, 1'b1, !bus}, "termination");
         if (!bus) chk(ev, absent ? 8'h0b : 8'h02, "vector");
         cyc(1);
         chk(wt, 0, "timeout pulse");
      end
      cyc(2);
   endtask
   task t_wdog;
      we = 1; wd(0, 0, 0, 0, 4); wd(1, 0, 0, 0, 4); wd(3, 0, 0, 0, 12); wd(200, 0, 0, 0, 512);
      wd(1, 1, 0, 0, 4); wd(1, 0, 1, 0, 4); wd(1, 0, 0, 2, 0);
      we = 0; wd(1, 0, 0, 0, 0);
      $display("watchdog test done");
   endtask
   task t_par(input logic [3:0] p, input logic [2:0] lvl);
      rd = 32'h0000_0103; be = 4'h3; rp = p; rv = 1; cyc(1); rv = 0;
      chk(il, 0, "early irq");
      cyc(1);
      chk({il, ivo}, {lvl, lvl == 3'h7}, "irq");
      ia = 1; cyc(1); ia = 0; cyc(2);
      chk(il, 0, "irq clear");
      $display("parity test done");
   endtask
   task t_exc;
      for (k = 0; k < 12; k++) begin
         ic = k[1:0]; fc = k[2:0]; ii = k < 4; fe = k >= 4; cyc(1); ii = 0; fe = 0;
         if (k < 4) chk({ex, ev}, {1'b1, k == 1 ? 8'h0a : k == 2 ? 8'h0b : 8'h04}, "illegal");
         else chk({ex, ev}, {1'b1, k[2:0] == 3'h7 ? 8'h36 : 8'h30 + 8'(k[2:0])}, "fp");
         cyc(1);
      end
      $display("exception test done");
   endtask
   initial begin
      cyc(12); srst = 0; cyc(1);
      t_status; t_cache; t_wdog;
      t_par(4'h2, 0); t_par(4'h6, 0); t_par(4'h0, 7);
      t_exc; conclude;
   end
endmodule // test_board_error_status_logic
